// ---- logic/cid_pkg.sv ----
/*
 * Shared types and constants for the core instruction decoder.
 * Assumes a single core clock and an active-high asynchronous reset.
 */
package cid_pkg;
	localparam int          CID_WORD_W       = 16;
	localparam int          CID_PHASES       = 4;
	localparam logic [1:0]  CID_PHASE_RST    = 2'h0;
	localparam logic [1:0]  CID_PHASE_LAST   = 2'h3;
	localparam logic [3:0]  CID_SECOND_TAG   = 4'hF;
	localparam logic [15:0] CID_NOP_WORD     = 16'h0000;
	localparam int          CID_STD_COUNT    = 75;
	localparam int          CID_EXT_COUNT    = 8;
	localparam logic [1:0]  CID_EXTRA_RST    = 2'h0;

	// Instruction category.
	typedef enum logic [2:0]
	{
		CID_CAT_BYTE,
		CID_CAT_BIT,
		CID_CAT_LITERAL,
		CID_CAT_CONTROL,
		CID_CAT_NOP
	} cid_cat_e;

	// Decoded operand fields of one instruction.
	typedef struct packed
	{
		cid_cat_e    cat;
		logic [5:0]  opcode;
		logic [7:0]  file_addr;
		logic        dest_to_file;
		logic        banked;
		logic [2:0]  bit_num;
		logic [7:0]  literal;
		logic [1:0]  fsp_sel;
		logic [19:0] prog_addr;
		logic        fast_mode;
		logic [1:0]  table_mode;
		logic        two_word;
		logic        is_branch;
		logic        extended;
	} cid_dec_s;
endpackage

// ---- logic/cid_field_split.sv ----
/*
 * Combinational splitter of a 16-bit word into category and operands.
 * Assumes the second word of a pair is presented on ext_word.
 */
`timescale 1ns/1ns
module cid_field_split
	import cid_pkg::*;
(
	input  wire logic [15:0] word,
	input  wire logic [15:0] ext_word,
	output cid_dec_s         dec
);
	// Operand extraction by opcode class.
	always_comb
	begin
		dec           = '0;
		dec.cat       = CID_CAT_NOP;
		dec.opcode    = word[15:10];
		dec.file_addr = word[7:0];
		dec.banked    = word[8];
		dec.literal   = word[7:0];
		unique casez (word[15:12])
			4'b0000:
			begin
				if (word[11:8] == 4'h0)
				begin
					dec.cat        = CID_CAT_CONTROL;
					dec.fast_mode  = word[0];
					dec.table_mode = word[1:0];
					if (word[7:0] == 8'h00)
						dec.cat = CID_CAT_NOP;
				end
				else if (word[11:8] == 4'hE)
				begin
					dec.cat      = CID_CAT_LITERAL;
					dec.extended = word[7];
					dec.fsp_sel  = word[5:4];
				end
				else
					dec.cat = CID_CAT_LITERAL;
			end
			4'b01??, 4'b0001, 4'b0010, 4'b0011:
			begin
				dec.cat          = CID_CAT_BYTE;
				dec.dest_to_file = word[9];
			end
			4'b1000, 4'b1001, 4'b1010, 4'b1011:
			begin
				dec.cat     = CID_CAT_BIT;
				dec.bit_num = word[11:9];
			end
			4'b1100:
			begin
				dec.cat       = CID_CAT_BYTE;
				dec.two_word  = 1'b1;
				dec.file_addr = word[7:0];
			end
			4'b1101:
			begin
				dec.cat       = CID_CAT_CONTROL;
				dec.prog_addr = {{9{word[10]}}, word[10:0]};
				dec.is_branch = 1'b1;
			end
			4'b1110:
			begin
				dec.cat       = CID_CAT_CONTROL;
				dec.prog_addr = {ext_word[11:0], word[7:0]};
				dec.two_word  = (word[11:9] == 3'h6) ||
				                (word[11:9] == 3'h7);
				dec.fast_mode = word[8];
				dec.is_branch = 1'b1;
			end
			4'b1111:
				dec.cat = CID_CAT_NOP;
			default:
				dec.cat = CID_CAT_NOP;
		endcase
	end
endmodule

// ---- logic/cid_core_decoder.sv ----
/*
 * Instruction decoder and cycle sequencer for an 8-bit core.
 * Assumes fetch presents a word with fetch_valid on the last phase and
 * that execute reports branch outcome on cond_true.
 */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
module cid_core_decoder
	import cid_pkg::*;
#(
	parameter int WORD_W = CID_WORD_W
)
(
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic [WORD_W-1:0] fetch_word,
	input  wire logic              fetch_valid,
	input  wire logic              cond_true,
	output cid_dec_s               dec_r,
	output logic                   issue_r,
	output logic                   nop_cycle_r,
	output logic                   wr_accum_r,
	output logic                   wr_file_r,
	output logic                   use_bank_select_r,
	output logic                   use_shadow_r,
	output logic [1:0]             phase_r,
	output logic                   cycle_end_r
);
	typedef enum logic [1:0]
	{
		CID_IDLE,
		CID_NEED_SECOND,
		CID_EXTRA
	} cid_state_e;

	cid_state_e                    state_r;
	cid_state_e                    state_nxt;
	logic [1:0]                    extra_r;
	logic [1:0]                    extra_nxt;
	logic [1:0]                    phase_nxt;
	logic [WORD_W-1:0]             first_r;
	logic [WORD_W-1:0]             first_nxt;
	cid_dec_s                      split;
	cid_dec_s                      dec_nxt;
	logic                          issue_nxt;
	logic                          nop_nxt;
	logic                          cyc_end;
	logic [WORD_W-1:0]             dec_word;
	logic [WORD_W-1:0]             dec_ext;

	////////////////////////////////////////////////////////////////////
	// True for a byte-oriented operation that is being issued.
	// Shared by both write-back steering flags so they cannot disagree.
	function automatic logic cid_byte_issue
	(
		input logic     issue,
		input cid_dec_s d
	);
		cid_byte_issue = issue && (d.cat == CID_CAT_BYTE);
	endfunction

	////////////////////////////////////////////////////////////////////
	// True when an issued instruction needs one trailing no-op cycle.
	// Any single-word program counter change (is_branch) always costs the
	// extra cycle; otherwise a true conditional test does.
	function automatic logic cid_needs_extra
	(
		input cid_dec_s d,
		input logic     cond
	);
		cid_needs_extra = d.is_branch || cond;
	endfunction

	////////////////////////////////////////////////////////////////////
	// True when a decoded word carries something to execute.
	// A lone second word or an all-zero word is a plain no-op.
	function automatic logic cid_is_real
	(
		input cid_dec_s d
	);
		cid_is_real = (d.cat != CID_CAT_NOP);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Field splitter sees the pending first word when a pair completes.
	assign dec_word = (state_r == CID_NEED_SECOND) ? first_r : fetch_word;
	assign dec_ext  = fetch_word;
	assign cyc_end  = (phase_r == CID_PHASE_LAST);

	cid_field_split u_split
	(
		.word     (dec_word),
		.ext_word (dec_ext),
		.dec      (split)
	);

	////////////////////////////////////////////////////////////////////
	// Phase counter and instruction sequencer next state.
	always_comb
	begin
		phase_nxt = phase_r + 2'h1;
		state_nxt = state_r;
		extra_nxt = extra_r;
		first_nxt = first_r;
		dec_nxt   = dec_r;
		issue_nxt = 1'b0;
		nop_nxt   = 1'b0;
		if (cyc_end)
		begin
			unique case (state_r)
				CID_IDLE:
				begin
					if (fetch_valid && split.two_word)
					begin
						// The first half of a pair is held, not run.
						first_nxt = fetch_word;
						state_nxt = CID_NEED_SECOND;
					end
					else if (fetch_valid && cid_is_real(split))
					begin
						dec_nxt   = split;
						issue_nxt = 1'b1;
						if (cid_needs_extra(split, cond_true))
						begin
							extra_nxt = 2'h1;
							state_nxt = CID_EXTRA;
						end
					end
					else if (fetch_valid)
						nop_nxt = 1'b1;
				end
				CID_NEED_SECOND:
				begin
					dec_nxt   = split;
					issue_nxt = 1'b1;
					state_nxt = CID_IDLE;
					if (split.is_branch && cond_true)
					begin
						extra_nxt = 2'h1;
						state_nxt = CID_EXTRA;
					end
				end
				CID_EXTRA:
				begin
					nop_nxt   = 1'b1;
					extra_nxt = extra_r - 2'h1;
					if (extra_r == 2'h1)
						state_nxt = CID_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sequencer registers.
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			phase_r     <= CID_PHASE_RST;
			state_r     <= CID_IDLE;
			extra_r     <= CID_EXTRA_RST;
			first_r     <= CID_NOP_WORD;
			dec_r       <= '0;
			issue_r     <= 1'b0;
			nop_cycle_r <= 1'b0;
			cycle_end_r <= 1'b0;
		end
		else
		begin
			phase_r     <= phase_nxt;
			state_r     <= state_nxt;
			extra_r     <= extra_nxt;
			first_r     <= first_nxt;
			dec_r       <= dec_nxt;
			issue_r     <= issue_nxt;
			nop_cycle_r <= nop_nxt;
			cycle_end_r <= cyc_end;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Write-back and bank steering drawn from the issued fields.
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			wr_accum_r        <= 1'b0;
			wr_file_r         <= 1'b0;
			use_bank_select_r <= 1'b0;
			use_shadow_r      <= 1'b0;
		end
		else
		begin
			wr_accum_r <= cid_byte_issue(issue_nxt, dec_nxt) &&
			              !dec_nxt.dest_to_file;
			wr_file_r  <= cid_byte_issue(issue_nxt, dec_nxt) &&
			              dec_nxt.dest_to_file;
			use_bank_select_r <= issue_nxt && dec_nxt.banked;
			use_shadow_r <= issue_nxt && dec_nxt.fast_mode &&
			                (dec_nxt.cat == CID_CAT_CONTROL);
		end
	end
endmodule

// ---- dv/cid_core_decoder_checker.sv ----
/* Port assertions for cid_core_decoder.
   Assumes it is bound into every decoder instance. */
`timescale 1ns/1ns
module cid_core_decoder_checker
	import cid_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       reset,
	input wire cid_dec_s   dec_r,
	input wire logic       issue_r,
	input wire logic       nop_cycle_r,
	input wire logic       wr_accum_r,
	input wire logic       wr_file_r,
	input wire logic       use_bank_select_r,
	input wire logic       use_shadow_r,
	input wire logic [1:0] phase_r,
	input wire logic       cycle_end_r
);
	////////////////////////////////////////////////////////////
	// All checks run on the core clock and rest during reset.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	chk_phase_step: assert property (!$past(reset) |->
		phase_r == $past(phase_r) + 2'h1) else $error("phase step");
	chk_cycle_end: assert property (!$past(reset) |->
		cycle_end_r == ($past(phase_r) == CID_PHASE_LAST))
		else $error("cycle end timing");
	chk_issue_edge: assert property (issue_r |->
		cycle_end_r) else $error("issue off cycle edge");
	chk_issue_gap: assert property (issue_r |=>
		!issue_r [*3]) else $error("issue too close");
	chk_dest_sel: assert property (wr_accum_r || wr_file_r |->
		issue_r && dec_r.cat == CID_CAT_BYTE && wr_file_r != wr_accum_r
		&& wr_file_r == dec_r.dest_to_file) else $error("destination");
	chk_bank_sel: assert property (issue_r &&
		dec_r.cat inside {CID_CAT_BYTE, CID_CAT_BIT} |->
		use_bank_select_r == dec_r.banked) else $error("bank select");
	chk_shadow_use: assert property (use_shadow_r |->
		issue_r && dec_r.fast_mode) else $error("shadow use");
	chk_dec_hold: assert property (!issue_r && !$past(reset) |->
		$stable(dec_r)) else $error("decode changed");
	chk_nop_quiet: assert property (nop_cycle_r |->
		!wr_accum_r && !wr_file_r && !use_shadow_r)
		else $error("no-op wrote");
endmodule

bind cid_core_decoder cid_core_decoder_checker cid_core_decoder_checker_inst
	(.*);

// ---- dv/cid_fetch_model.sv ----
/* Program memory fetch model for the decoder bench.
   Assumes the bench supplies the next word on req_word. */
`timescale 1ns/1ns
module cid_fetch_model
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [1:0]  phase_r,
	input  wire logic        req_on,
	input  wire logic [15:0] req_word,
	output logic [15:0]      fetch_word,
	output logic             fetch_valid
);
	// One whole word per cycle, scrambled once its sample edge passed.
	always_ff @(posedge ref_clk or posedge reset)
		if (reset)
		begin
			fetch_word <= 16'h0000;
			fetch_valid <= 1'b0;
		end
		else if (phase_r == 2'h2 && req_on)
		begin
			fetch_word <= req_word;
			fetch_valid <= 1'b1;
		end
		else
		begin
			fetch_word <= ~fetch_word;
			fetch_valid <= 1'b0;
		end
endmodule

// ---- dv/cid_core_decoder_tb_top.sv ----
/* Self-checking bench for cid_core_decoder.
   Assumes the fetch model and the bound checker. */
`timescale 1ns/1ns
module cid_core_decoder_tb_top
	import cid_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        cond_true = 1'b0;
	logic        req_on = 1'b0;
	logic [15:0] req_word = 16'h0000;
	logic [15:0] fetch_word;
	logic        fetch_valid, issue_r, nop_cycle_r, wr_accum_r, wr_file_r;
	logic        bank_r, shadow_r, end_r;
	logic [1:0]  phase_r;
	cid_dec_s    dec_r, got;
	logic [7:0]  n_iss, n_nop, flg;
	int          err_total = 0;
	int          tests_run = 0;
	int          cycles = 0;
	////////////////////////////////////////////////////////////
	cid_core_decoder cid_core_decoder_inst (.ref_clk(ref_clk),
		.reset(reset), .fetch_word(fetch_word), .fetch_valid(fetch_valid),
		.cond_true(cond_true), .dec_r(dec_r), .issue_r(issue_r),
		.nop_cycle_r(nop_cycle_r), .wr_accum_r(wr_accum_r),
		.wr_file_r(wr_file_r), .use_bank_select_r(bank_r),
		.use_shadow_r(shadow_r), .phase_r(phase_r), .cycle_end_r(end_r));
	cid_fetch_model cid_fetch_model_inst (.ref_clk(ref_clk), .reset(reset),
		.phase_r(phase_r), .req_on(req_on), .req_word(req_word),
		.fetch_word(fetch_word), .fetch_valid(fetch_valid));
	// Clock and a hang limit well above the planned run.
	initial forever #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			err_total++;
			end_sim;
		end
	end
	task end_sim;
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task feed(input logic [15:0] w, input logic c);
		do
		begin
			@(posedge ref_clk);
			#1;
		end
		while (phase_r !== 2'h2);
		req_word <= w;
		req_on <= 1'b1;
		cond_true <= c;
	endtask
	// Sends one or two words, then gathers the pulses that follow.
	task run(input logic [15:0] w1, input logic [15:0] w2, input logic c);
		n_iss = 8'h00;
		n_nop = 8'h00;
		feed(w1, c);
		if (w2 != 16'h0000)
			feed(w2, c);
		@(posedge ref_clk);
		req_on <= 1'b0;
		repeat (16)
		begin
			@(posedge ref_clk);
			#1;
			if (issue_r === 1'b1)
			begin
				n_iss++;
				got = dec_r;
				flg = {4'h0, wr_accum_r, wr_file_r, bank_r, shadow_r};
			end
			if (nop_cycle_r === 1'b1)
				n_nop++;
		end
		cond_true <= 1'b0;
	endtask
	task t_byte;
		run(16'h27AB, 16'h0000, 1'b0);
		chk("issues", 8'h01, n_iss);
		chk("cat", 8'(CID_CAT_BYTE), 8'(got.cat));
		chk("flags", 8'h06, flg);
		chk("addr", 8'hAB, got.file_addr);
		chk("nops", 8'h00, n_nop);
		run(16'h2455, 16'h0000, 1'b0);
		chk("flags", 8'h08, flg);
	endtask
	task t_bit;
		run(16'h8B12, 16'h0000, 1'b0);
		chk("cat", 8'(CID_CAT_BIT), 8'(got.cat));
		chk("bit", 8'h05, 8'(got.bit_num));
		chk("flags", 8'h02, flg);
	endtask
	task t_lit;
		run(16'h0E5A, 16'h0000, 1'b0);
		chk("cat", 8'(CID_CAT_LITERAL), 8'(got.cat));
		chk("lit", 8'h5A, got.literal);
	endtask
	task t_ctl;
		run(16'h0013, 16'h0000, 1'b1);
		chk("cat", 8'(CID_CAT_CONTROL), 8'(got.cat));
		chk("flags", 8'h01, flg);
		chk("nops", 8'h01, n_nop);
	endtask
	task t_lone;
		run(16'hF123, 16'h0000, 1'b0);
		chk("nops", 8'h01, n_nop);
	endtask
	task t_two;
		run(16'hC123, 16'hF456, 1'b0);
		chk("issues", 8'h01, n_iss);
		chk("two", 8'h01, 8'(got.two_word));
		chk("nops", 8'h00, n_nop);
		run(16'hEF12, 16'hF345, 1'b1);
		chk("nops", 8'h01, n_nop);
	endtask
	// Reset, then each scenario in turn.
	initial
	begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		t_byte;
		t_bit;
		t_lit;
		t_ctl;
		t_lone;
		t_two;
		end_sim;
	end
endmodule
